// ### hdl/lpwc_top.sv
`timescale 1ns/1ns
// Behaviour
// [R1] dma done with enable wakes in wait/doze
// [R2] dma error with enable wakes in wait/doze
// [R3] dma frozen in stop, no stop wake
// [R4] external bus never wakes, frozen in stop
// [R5] dram controller clockless in stop, no refresh
// [R6] software puts dram into self refresh first
// [R7] setting dram clock enable exits self refresh
// [R8] software keeps vectors out of dram
// [R9] ethernet frozen in stop, may wake otherwise
// [R10] watchdog freezes in stop or configured wait/doze
// [R11] periodic timers freeze in stop or configured doze
// [R12] timer capture wakes when dma request off
// [R13] timer compare wakes when dma request off
// [R14] dma timers disabled in stop, resume after
// [R15] spi frozen in stop, may wake otherwise
// [R16] uarts frozen in stop, may wake otherwise
// [R17] serial bus wakes only enabled, unstopped, irq enabled
// [R18] serial flag on byte done or address match
// [R19] serial bus frozen in stop, resumes after
// [R20] breakpoint halts, exits low power, returns after
// [R21] test port never wakes the cpu
// [R22] peripherals take status from mode at stop
// [R23] mode select picks stop, wait or doze
// [R24] interrupt wake needs priority and all masks
// [R25] all qualified sources merge into one wake
module lpwc_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic stop_exec,
    input wire logic [1:0] low_power_mode_select,
    input wire logic [lpwc_pkg::PRI_W-1:0] wake_priority_threshold,
    input wire logic debug_breakpoint_pin,
    input wire logic [lpwc_pkg::DMA_CH-1:0] channel_done_irq_enable,
    input wire logic [lpwc_pkg::DMA_CH-1:0] channel_done,
    input wire logic [lpwc_pkg::DMA_CH-1:0] channel_error_irq_enable,
    input wire logic [lpwc_pkg::ERR_W-1:0] dma_error_status,
    input wire logic [lpwc_pkg::DMA_CH-1:0] dma_error_channel,
    input wire logic ethernet_irq,
    input wire logic spi_irq,
    input wire logic [lpwc_pkg::NUM_UART-1:0] uart_irq,
    input wire logic watchdog_lowpwr_freeze,
    input wire logic watchdog_reset_req,
    input wire logic [lpwc_pkg::NUM_PIT-1:0] periodic_timer_doze_freeze,
    input wire logic [lpwc_pkg::NUM_PIT-1:0] periodic_timer_irq,
    input wire logic [lpwc_pkg::NUM_TMR-1:0] timer_capture_edge_nz,
    input wire logic [lpwc_pkg::NUM_TMR-1:0] timer_capture_event,
    input wire logic [lpwc_pkg::NUM_TMR-1:0] compare_irq_enable,
    input wire logic [lpwc_pkg::NUM_TMR-1:0] timer_ref_reached,
    input wire logic [lpwc_pkg::NUM_TMR-1:0] timer_dma_request_enable,
    input wire logic serial_module_enable,
    input wire logic serial_irq_enable,
    input wire logic serial_byte_done,
    input wire logic serial_addr_match,
    input wire logic serial_slave_rx,
    input wire logic serial_flag_clear,
    input wire logic dram_clock_enable,
    input wire logic irq_valid,
    input wire logic [lpwc_pkg::PRI_W-1:0] irq_priority,
    input wire logic [lpwc_pkg::PRI_W-1:0] core_irq_mask,
    input wire logic irq_ctrl_unmasked,
    input wire logic irq_source_enabled,
    input wire logic test_port_event,
    output logic [1:0] active_mode,
    output logic cpu_halted,
    output logic wake_req,
    output logic [lpwc_pkg::FRZ_W-1:0] periph_freeze,
    output logic [lpwc_pkg::NUM_PIT-1:0] periodic_timer_freeze,
    output logic dma_timer_enable,
    output logic dram_self_refresh,
    output logic dma_wake_irq,
    output logic dma_err_wake_irq,
    output logic [lpwc_pkg::NUM_TMR-1:0] timer_wake_irq,
    output logic serial_irq_flag,
    output logic serial_wake_irq
);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic any_bits(input logic [lpwc_pkg::ERR_W-1:0] v);
        any_bits = |v;
    endfunction : any_bits

    lpwc_pkg::lpwc_state_e state_q, state_d;
    logic [1:0] mode_q, mode_d;
    logic halted_q;
    logic wake_q;
    logic [lpwc_pkg::FRZ_W-1:0] frz_q;
    logic [lpwc_pkg::NUM_PIT-1:0] pit_frz_q;
    logic tmr_en_q;
    logic sref_q;
    logic dma_wk_q, dma_err_q;
    logic [lpwc_pkg::NUM_TMR-1:0] tmr_wk_q;
    logic sflag_q, swk_q;
    logic [lpwc_pkg::ERR_W-1:0] err_prev_q;

    ////////////////////////////////////////////////////////////////////////
    wire in_lp = (state_q == lpwc_pkg::ST_LOWPWR);
    wire in_stop = in_lp && (mode_q == lpwc_pkg::MODE_STOP);
    wire in_wd = in_lp && (mode_q != lpwc_pkg::MODE_STOP);
    wire in_doze = in_lp && (mode_q == lpwc_pkg::MODE_DOZE);
    wire [lpwc_pkg::ERR_W-1:0] err_rise = dma_error_status & ~err_prev_q;
    wire dma_done_hit = |(channel_done & channel_done_irq_enable); // [R1]
    wire dma_err_hit = any_bits(err_rise) && |(dma_error_channel & channel_error_irq_enable); // [R2]
    wire [lpwc_pkg::NUM_TMR-1:0] tmr_hit = (timer_capture_edge_nz & timer_capture_event & ~timer_dma_request_enable)
        | (compare_irq_enable & timer_ref_reached & ~timer_dma_request_enable); // [R12] [R13]
    wire sflag_set = !in_stop && serial_module_enable
        && (serial_byte_done || (serial_slave_rx && serial_addr_match)); // [R18] [R19]
    wire swk_d = sflag_q && serial_irq_enable && serial_module_enable && !in_stop; // [R17]
    // interrupt controller qualification
    wire irq_ok = irq_valid && (irq_priority > wake_priority_threshold)
        && (irq_priority > core_irq_mask) && irq_ctrl_unmasked && irq_source_enabled; // [R24]
    // dma, ethernet, spi and uart only count outside stop; test port never counts
    wire wd_src = (dma_wk_q || dma_err_q || ethernet_irq || spi_irq || (|uart_irq)
        || (|tmr_wk_q) || (|periodic_timer_irq) || swk_q); // [R3] [R9] [R15] [R16] [R21]
    wire wake_d = in_lp && irq_ok && (in_wd ? wd_src : 1'b0)
        || (in_wd && watchdog_reset_req && !watchdog_lowpwr_freeze)
        || (in_lp && debug_breakpoint_pin); // [R25] [R10] [R20]
    wire [lpwc_pkg::FRZ_W-1:0] frz_d = {lpwc_pkg::FRZ_W{in_stop}}; // [R22]
    wire wdog_frz = in_stop || (in_wd && watchdog_lowpwr_freeze); // [R10]
    wire [lpwc_pkg::NUM_PIT-1:0] pit_frz_d = {lpwc_pkg::NUM_PIT{in_stop}}
        | ({lpwc_pkg::NUM_PIT{in_doze}} & periodic_timer_doze_freeze); // [R11]

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_d = state_q;
        mode_d = mode_q;
        unique case (state_q)
            lpwc_pkg::ST_RUN: begin
                if (debug_breakpoint_pin) begin
                    state_d = lpwc_pkg::ST_HALT;
                end else if (stop_exec && low_power_mode_select != lpwc_pkg::MODE_RUN) begin
                    state_d = lpwc_pkg::ST_LOWPWR;
                    mode_d = low_power_mode_select; // [R23]
                end
            end
            lpwc_pkg::ST_LOWPWR: begin
                if (debug_breakpoint_pin) begin
                    state_d = lpwc_pkg::ST_HALT; // [R20]
                end else if (wake_d) begin
                    state_d = lpwc_pkg::ST_RUN;
                    mode_d = lpwc_pkg::MODE_RUN;
                end
            end
            lpwc_pkg::ST_HALT: begin
                // leaving halt re-enters the prior mode, if any
                if (!debug_breakpoint_pin) begin
                    state_d = (mode_q == lpwc_pkg::MODE_RUN) ? lpwc_pkg::ST_RUN : lpwc_pkg::ST_LOWPWR; // [R20]
                end
            end
            default: begin
                state_d = lpwc_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= lpwc_pkg::ST_RUN;
            mode_q <= lpwc_pkg::RESET_MODE;
        end else begin
            state_q <= state_d;
            mode_q <= mode_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            halted_q <= 1'b0;
            wake_q <= 1'b0;
            frz_q <= '0;
            pit_frz_q <= '0;
            tmr_en_q <= 1'b1;
        end else begin
            halted_q <= (state_d == lpwc_pkg::ST_HALT);
            wake_q <= wake_d;
            frz_q <= {frz_d[lpwc_pkg::FRZ_W-1:lpwc_pkg::FRZ_WDOG+1], wdog_frz,
                frz_d[lpwc_pkg::FRZ_WDOG-1:0]}; // [R3] [R4] [R5] [R9] [R15] [R16] [R19]
            pit_frz_q <= pit_frz_d; // [R11]
            tmr_en_q <= !in_stop; // [R14]
        end
    end

    // self refresh held from stop until clock enable is set again
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sref_q <= 1'b0;
        end else if (in_stop && !dram_clock_enable) begin
            sref_q <= 1'b1; // [R6]
        end else if (!in_stop && dram_clock_enable) begin
            sref_q <= 1'b0; // [R7]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dma_wk_q <= 1'b0;
            dma_err_q <= 1'b0;
            tmr_wk_q <= '0;
            err_prev_q <= '0;
            sflag_q <= 1'b0;
            swk_q <= 1'b0;
        end else begin
            dma_wk_q <= in_wd && dma_done_hit; // [R1] [R3]
            dma_err_q <= in_wd && dma_err_hit; // [R2] [R3]
            tmr_wk_q <= {lpwc_pkg::NUM_TMR{in_wd}} & tmr_hit; // [R12] [R13] [R14]
            err_prev_q <= in_stop ? err_prev_q : dma_error_status;
            // set wins over clear
            if (sflag_set) begin
                sflag_q <= 1'b1; // [R18]
            end else if (serial_flag_clear) begin
                sflag_q <= 1'b0;
            end
            swk_q <= swk_d; // [R17]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign active_mode = mode_q;
    assign cpu_halted = halted_q;
    assign wake_req = wake_q;
    assign periph_freeze = frz_q;
    assign periodic_timer_freeze = pit_frz_q;
    assign dma_timer_enable = tmr_en_q;
    assign dram_self_refresh = sref_q;
    assign dma_wake_irq = dma_wk_q;
    assign dma_err_wake_irq = dma_err_q;
    assign timer_wake_irq = tmr_wk_q;
    assign serial_irq_flag = sflag_q;
    assign serial_wake_irq = swk_q;

    ////////////////////////////////////////////////////////////////////////
    sequence s_stop_entered;
        in_stop;
    endsequence

    property p_dma_done;
        @(posedge clk) disable iff (rst) (in_wd && dma_done_hit) |=> dma_wake_irq;
    endproperty
    a_dma_done: assert property (p_dma_done) else $error("dma done wake missing"); // [R1]

    property p_dma_err;
        @(posedge clk) disable iff (rst) (in_wd && dma_err_hit) |=> dma_err_wake_irq;
    endproperty
    a_dma_err: assert property (p_dma_err) else $error("dma error wake missing"); // [R2]

    property p_dma_stop;
        @(posedge clk) disable iff (rst) s_stop_entered |=> !dma_wake_irq && !dma_err_wake_irq;
    endproperty
    a_dma_stop: assert property (p_dma_stop) else $error("dma woke from stop"); // [R3]

    property p_freeze_stop;
        @(posedge clk) disable iff (rst) s_stop_entered |=> (&periph_freeze) && !dma_timer_enable;
    endproperty
    a_freeze_stop: assert property (p_freeze_stop) else $error("stop freeze missing"); // [R14]

    property p_no_freeze_run;
        @(posedge clk) disable iff (rst) (state_q == lpwc_pkg::ST_RUN) |=> periph_freeze[lpwc_pkg::FRZ_ETH] == 1'b0;
    endproperty
    a_no_freeze_run: assert property (p_no_freeze_run) else $error("freeze outside stop"); // [R9]

    property p_pit_doze;
        @(posedge clk) disable iff (rst) (in_doze && periodic_timer_doze_freeze[0]) |=> periodic_timer_freeze[0];
    endproperty
    a_pit_doze: assert property (p_pit_doze) else $error("timer doze freeze missing"); // [R11]

    property p_serial_stop;
        @(posedge clk) disable iff (rst) s_stop_entered |=> !serial_wake_irq;
    endproperty
    a_serial_stop: assert property (p_serial_stop) else $error("serial woke in stop"); // [R17]

    property p_debug_breakpoint_pin;
        @(posedge clk) disable iff (rst) (in_lp && debug_breakpoint_pin) |=> cpu_halted && wake_req;
    endproperty
    a_debug_breakpoint_pin: assert property (p_debug_breakpoint_pin) else $error("breakpoint did not halt"); // [R20]

    property p_mode_sel;
        @(posedge clk) disable iff (rst)
            (state_q == lpwc_pkg::ST_RUN && stop_exec && !debug_breakpoint_pin
            && low_power_mode_select != lpwc_pkg::MODE_RUN) |=> active_mode == $past(low_power_mode_select);
    endproperty
    a_mode_sel: assert property (p_mode_sel) else $error("wrong mode entered"); // [R23]

    property p_sref_exit;
        @(posedge clk) disable iff (rst) (!in_stop && dram_clock_enable) |=> !dram_self_refresh;
    endproperty
    a_sref_exit: assert property (p_sref_exit) else $error("self refresh not left"); // [R7]

    sequence s_halt_release;
        state_q == lpwc_pkg::ST_HALT && !debug_breakpoint_pin && active_mode != lpwc_pkg::MODE_RUN;
    endsequence

    sequence s_back_in_lowpwr;
        in_lp && !cpu_halted;
    endsequence

    property p_halt_resume;
        @(posedge clk) disable iff (rst) s_halt_release |=> s_back_in_lowpwr;
    endproperty
    a_halt_resume: assert property (p_halt_resume) else $error("prior low power mode not resumed"); // [R20]

    property p_halt_keep_mode;
        @(posedge clk) disable iff (rst) (state_q == lpwc_pkg::ST_HALT) |=> active_mode == $past(active_mode);
    endproperty
    a_halt_keep_mode: assert property (p_halt_keep_mode) else $error("mode lost during halt"); // [R20]

    property p_stop_no_wake;
        @(posedge clk) disable iff (rst) (in_stop && !debug_breakpoint_pin) |=> !wake_req;
    endproperty
    a_stop_no_wake: assert property (p_stop_no_wake) else $error("peripheral woke from stop"); // [R3] [R4] [R9] [R15] [R16]

    property p_irq_qual;
        @(posedge clk) disable iff (rst) (in_lp && !irq_ok && !watchdog_reset_req && !debug_breakpoint_pin) |=> !wake_req;
    endproperty
    a_irq_qual: assert property (p_irq_qual) else $error("unqualified interrupt woke cpu"); // [R24]

    property p_test_port;
        @(posedge clk) disable iff (rst)
            (in_wd && test_port_event && !wd_src && !watchdog_reset_req && !debug_breakpoint_pin) |=> !wake_req;
    endproperty
    a_test_port: assert property (p_test_port) else $error("test port woke cpu"); // [R21]

    property p_watchdog_wake;
        @(posedge clk) disable iff (rst) (in_wd && watchdog_reset_req && !watchdog_lowpwr_freeze) |=> wake_req;
    endproperty
    a_watchdog_wake: assert property (p_watchdog_wake) else $error("watchdog reset did not wake"); // [R10]

    property p_wdog_freeze;
        @(posedge clk) disable iff (rst) (in_wd && watchdog_lowpwr_freeze) |=> periph_freeze[lpwc_pkg::FRZ_WDOG];
    endproperty
    a_wdog_freeze: assert property (p_wdog_freeze) else $error("watchdog not frozen"); // [R10]

    property p_timer_wake;
        @(posedge clk) disable iff (rst) (in_wd && (|tmr_hit)) |=> (|timer_wake_irq);
    endproperty
    a_timer_wake: assert property (p_timer_wake) else $error("timer wake missing"); // [R12] [R13]

    property p_serial_flag;
        @(posedge clk) disable iff (rst) sflag_set |=> serial_irq_flag;
    endproperty
    a_serial_flag: assert property (p_serial_flag) else $error("serial flag not set"); // [R18]

    property p_serial_enable;
        @(posedge clk) disable iff (rst) (!serial_module_enable || !serial_irq_enable) |=> !serial_wake_irq;
    endproperty
    a_serial_enable: assert property (p_serial_enable) else $error("serial woke while disabled"); // [R17]

    property p_sref_hold;
        @(posedge clk) disable iff (rst) (dram_self_refresh && !dram_clock_enable) |=> dram_self_refresh;
    endproperty
    a_sref_hold: assert property (p_sref_hold) else $error("self refresh left early"); // [R7]

    property p_pit_stop;
        @(posedge clk) disable iff (rst) s_stop_entered |=> (&periodic_timer_freeze);
    endproperty
    a_pit_stop: assert property (p_pit_stop) else $error("timer stop freeze missing"); // [R11]

endmodule : lpwc_top

// ### hdl/lpwc_pkg.sv
package lpwc_pkg;
    // low power mode select encoding
    localparam logic [1:0] MODE_RUN = 2'h0;
    localparam logic [1:0] MODE_DOZE = 2'h1;
    localparam logic [1:0] MODE_WAIT = 2'h2;
    localparam logic [1:0] MODE_STOP = 2'h3;
    localparam int DMA_CH = 16;
    localparam int ERR_W = 32;
    localparam int NUM_PIT = 4;
    localparam int NUM_TMR = 4;
    localparam int NUM_UART = 3;
    localparam int PRI_W = 3;
    localparam logic [1:0] RESET_MODE = 2'h0;
    localparam logic [PRI_W-1:0] RESET_PRI = 3'h0;
    localparam int FRZ_W = 8;
    // freeze bit positions
    localparam int FRZ_DMA = 0;
    localparam int FRZ_BUS = 1;
    localparam int FRZ_DRAM = 2;
    localparam int FRZ_ETH = 3;
    localparam int FRZ_WDOG = 4;
    localparam int FRZ_SPI = 5;
    localparam int FRZ_UART = 6;
    localparam int FRZ_I2C = 7;
    typedef enum logic [1:0] {
        ST_RUN,
        ST_LOWPWR,
        ST_HALT
    } lpwc_state_e;
endpackage : lpwc_pkg

// ### testbench/lpwc_cpu_model.sv
`timescale 1ns/1ns
// cpu and software side: issues the stop instruction, parks dram before stop
module lpwc_cpu_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    input wire logic [1:0] mode_req,
    input wire logic wake_req,
    output logic stop_exec,
    output logic [1:0] low_power_mode_select,
    output logic dram_clock_enable
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stop_exec <= 1'b0;
            low_power_mode_select <= 2'h0;
            dram_clock_enable <= 1'b1;
        end else begin
            stop_exec <= go;
            if (go) begin
                low_power_mode_select <= mode_req;
            end
            // self refresh before stop; code never fetched from dram while asleep
            if (go && mode_req == lpwc_pkg::MODE_STOP) begin
                dram_clock_enable <= 1'b0;
            end else if (wake_req) begin
                dram_clock_enable <= 1'b1;
            end
        end
    end
endmodule : lpwc_cpu_model

// ### testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic clk, rst, go, stop_exec, debug_breakpoint_pin, dram_clock_enable, wake_seen;
    logic [1:0] mode_req, low_power_mode_select, active_mode, m;
    logic [2:0] wake_priority_threshold, irq_priority, core_irq_mask, uart_irq;
    logic [15:0] channel_done_irq_enable, channel_done, channel_error_irq_enable, dma_error_channel;
    logic [31:0] dma_error_status;
    logic ethernet_irq, spi_irq, watchdog_lowpwr_freeze, watchdog_reset_req, irq_valid;
    logic [3:0] periodic_timer_doze_freeze, periodic_timer_irq, timer_capture_edge_nz, timer_capture_event;
    logic [3:0] compare_irq_enable, timer_ref_reached, timer_dma_request_enable, periodic_timer_freeze, timer_wake_irq;
    logic serial_module_enable, serial_irq_enable, serial_byte_done, serial_addr_match, serial_slave_rx;
    logic serial_flag_clear, irq_ctrl_unmasked, irq_source_enabled, test_port_event, cpu_halted, wake_req;
    logic dma_timer_enable, dram_self_refresh, dma_wake_irq, dma_err_wake_irq, serial_irq_flag, serial_wake_irq;
    logic [7:0] periph_freeze, e;
    int fail_count, tests_run, cycles;
    lpwc_cpu_model u_lpwc_cpu_model (.clk(clk), .rst(rst), .go(go), .mode_req(mode_req), .wake_req(wake_req),
        .stop_exec(stop_exec), .low_power_mode_select(low_power_mode_select), .dram_clock_enable(dram_clock_enable));
    lpwc_top u_lpwc_top (.clk(clk), .rst(rst), .stop_exec(stop_exec), .low_power_mode_select(low_power_mode_select),
        .wake_priority_threshold(wake_priority_threshold), .debug_breakpoint_pin(debug_breakpoint_pin),
        .channel_done_irq_enable(channel_done_irq_enable), .channel_done(channel_done),
        .channel_error_irq_enable(channel_error_irq_enable), .dma_error_status(dma_error_status),
        .dma_error_channel(dma_error_channel), .ethernet_irq(ethernet_irq), .spi_irq(spi_irq), .uart_irq(uart_irq),
        .watchdog_lowpwr_freeze(watchdog_lowpwr_freeze), .watchdog_reset_req(watchdog_reset_req),
        .periodic_timer_doze_freeze(periodic_timer_doze_freeze), .periodic_timer_irq(periodic_timer_irq),
        .timer_capture_edge_nz(timer_capture_edge_nz), .timer_capture_event(timer_capture_event),
        .compare_irq_enable(compare_irq_enable), .timer_ref_reached(timer_ref_reached),
        .timer_dma_request_enable(timer_dma_request_enable), .serial_module_enable(serial_module_enable),
        .serial_irq_enable(serial_irq_enable), .serial_byte_done(serial_byte_done),
        .serial_addr_match(serial_addr_match), .serial_slave_rx(serial_slave_rx),
        .serial_flag_clear(serial_flag_clear), .dram_clock_enable(dram_clock_enable), .irq_valid(irq_valid),
        .irq_priority(irq_priority), .core_irq_mask(core_irq_mask), .irq_ctrl_unmasked(irq_ctrl_unmasked),
        .irq_source_enabled(irq_source_enabled), .test_port_event(test_port_event), .active_mode(active_mode),
        .cpu_halted(cpu_halted), .wake_req(wake_req), .periph_freeze(periph_freeze),
        .periodic_timer_freeze(periodic_timer_freeze), .dma_timer_enable(dma_timer_enable),
        .dram_self_refresh(dram_self_refresh), .dma_wake_irq(dma_wake_irq), .dma_err_wake_irq(dma_err_wake_irq),
        .timer_wake_irq(timer_wake_irq), .serial_irq_flag(serial_irq_flag), .serial_wake_irq(serial_wake_irq));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (wake_req === 1'b1) wake_seen = 1'b1;
        if (cycles == 3000) begin
            fail_count++;
            end_sim();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // idle sources, interrupt path fully qualified
    task automatic clr_src();
        {channel_done_irq_enable, channel_done, channel_error_irq_enable, dma_error_channel} = '0;
        {dma_error_status, ethernet_irq, spi_irq, uart_irq, periodic_timer_irq, watchdog_reset_req} = '0;
        {timer_capture_edge_nz, timer_capture_event, compare_irq_enable, timer_ref_reached} = '0;
        {timer_dma_request_enable, serial_module_enable, serial_irq_enable, serial_byte_done} = '0;
        {serial_addr_match, serial_slave_rx, serial_flag_clear, test_port_event} = '0;
        {irq_valid, irq_ctrl_unmasked, irq_source_enabled} = 3'h7;
        irq_priority = 3'h5;
        wake_priority_threshold = 3'h2;
        core_irq_mask = 3'h2;
    endtask : clr_src
    task automatic do_reset();
        rst = 1'b1;
        clr_src();
        step(4);
        rst = 1'b0;
        step(1);
    endtask : do_reset
    task automatic enter(input logic [1:0] md);
        go = 1'b1;
        mode_req = md;
        wake_seen = 1'b0;
        step(1);
        go = 1'b0;
        step(3);
    endtask : enter
    // 0..10 must wake, 11..17 must not
    task automatic set_src(input int k);
        case (k)
            0: {channel_done_irq_enable, channel_done} = {16'h8000, 16'h8000};
            1: {channel_error_irq_enable, dma_error_channel, dma_error_status} = {16'h0001, 16'h0001, 32'h00000001};
            2: ethernet_irq = 1'b1;
            3: spi_irq = 1'b1;
            4: uart_irq = 3'h4;
            5: periodic_timer_irq = 4'h8;
            6: watchdog_reset_req = 1'b1;
            7, 11: {timer_capture_edge_nz, timer_capture_event} = {4'h2, 4'h2};
            8: {compare_irq_enable, timer_ref_reached} = {4'h1, 4'h1};
            9: {serial_module_enable, serial_irq_enable, serial_byte_done} = 3'h7;
            10: {serial_module_enable, serial_irq_enable, serial_slave_rx, serial_addr_match} = 4'hF;
            12: {serial_irq_enable, serial_byte_done} = 2'h3;
            13: test_port_event = 1'b1;
            14: {ethernet_irq, irq_priority} = {1'b1, 3'h2};
            15: {ethernet_irq, irq_ctrl_unmasked} = 2'h2;
            16: {ethernet_irq, irq_source_enabled} = 2'h2;
            default: {ethernet_irq, core_irq_mask} = {1'b1, 3'h5};
        endcase
        if (k == 11) timer_dma_request_enable = 4'h2;
    endtask : set_src
    task automatic end_sim();
        $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, go, mode_req, debug_breakpoint_pin, wake_seen} = 6'h20;
        {watchdog_lowpwr_freeze, periodic_timer_doze_freeze, fail_count, tests_run, cycles} = '0;
        clr_src();
        do_reset();
        for (int k = 0; k < 18; k++) begin
            m = k[0] ? lpwc_pkg::MODE_DOZE : lpwc_pkg::MODE_WAIT;
            enter(m);
            chk({6'h0, active_mode}, {6'h0, m});
            set_src(k);
            step(1);
            e = (k == 0) ? 8'h20 : (k == 1) ? 8'h10 : (k == 7) ? 8'h02 : (k == 8) ? 8'h01 : 8'h00;
            chk({2'h0, dma_wake_irq, dma_err_wake_irq, timer_wake_irq}, e);
            step(3);
            chk({7'h0, wake_seen}, {7'h0, k < 11});
            chk({6'h0, active_mode}, k < 11 ? 8'h00 : {6'h0, m});
            e = (k == 12) ? 8'h00 : 8'h03;
            if (k == 9 || k == 10 || k == 12) chk({6'h0, serial_irq_flag, serial_wake_irq}, e);
            do_reset();
        end
        $display("wake sources done");
        {watchdog_lowpwr_freeze, periodic_timer_doze_freeze} = 5'h15;
        for (int md = 1; md < 3; md++) begin
            enter(md[1:0]);
            chk(periph_freeze, 8'h10);
            chk({4'h0, periodic_timer_freeze}, md == 1 ? 8'h05 : 8'h00);
            chk({7'h0, dma_timer_enable}, 8'h01);
            watchdog_reset_req = 1'b1;
            step(2);
            chk({6'h0, wake_seen, active_mode != 2'h0}, 8'h01);
            do_reset();
        end
        $display("doze and wait freeze done");
        enter(lpwc_pkg::MODE_STOP);
        chk({6'h0, active_mode}, 8'h03);
        chk(periph_freeze, 8'hFF);
        chk({4'h0, periodic_timer_freeze}, 8'h0F);
        chk({6'h0, dram_self_refresh, dma_timer_enable}, 8'h02);
        set_src(0);
        set_src(2);
        set_src(9);
        step(4);
        chk({7'h0, wake_seen}, 8'h00);
        debug_breakpoint_pin = 1'b1;
        step(3);
        chk({6'h0, wake_seen, cpu_halted}, 8'h03);
        debug_breakpoint_pin = 1'b0;
        step(3);
        chk({5'h0, cpu_halted, active_mode}, 8'h03);
        serial_flag_clear = 1'b1;
        step(1);
        chk({7'h0, serial_irq_flag}, 8'h00);
        do_reset();
        chk({5'h0, dma_timer_enable, active_mode}, 8'h04);
        $display("stop and halt done");
        end_sim();
    end
endmodule : tb_top
